//--- ccu_params.svh
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

// Register byte offsets
`define CCU_TCTRL      12'h000
`define CCU_T0CNT      12'h004
`define CCU_T0REL      12'h008
`define CCU_T1CNT      12'h00c
`define CCU_T1REL      12'h010
`define CCU_ISTAT      12'h014
`define CCU_IMASK      12'h018
`define CCU_DREG       12'h01c
`define CCU_VAL_BASE   12'h040
`define CCU_MODE_BASE  12'h080
`define CCU_BANK_MASK  12'hfc0

// Timer control fields
`define CCU_F_RUN0     0
`define CCU_F_SEL0     1
`define CCU_T_STRIDE   8
`define CCU_F_STAG     16

// Channel mode fields
`define CCU_F_RISE     3
`define CCU_F_FALL     4
`define CCU_F_TSEL     5
`define CCU_F_SING     6

// Reset values
`define CCU_RST_TCTRL  17'h00000
`define CCU_RST_CNT    16'h0000
`define CCU_RST_REL    16'h0000
`define CCU_RST_MODE   7'h00

// Timing
`define CCU_STAGGER    8

// Bus responses
`define CCU_OKAY       2'h0
`define CCU_SLVERR     2'h2

`endif

//--- ccu_pkg.sv
package ccu_pkg;

  typedef enum logic [2:0] {
    CCU_OFF  = 3'h0,
    CCU_CAP  = 3'h1,
    CCU_CMP0 = 3'h4,
    CCU_CMP1 = 3'h5,
    CCU_CMP2 = 3'h6,
    CCU_CMP3 = 3'h7
  } ccu_kind_t;

  typedef enum logic [2:0] {
    CCU_DIV1   = 3'h0,
    CCU_DIV4   = 3'h1,
    CCU_DIV16  = 3'h2,
    CCU_DIV64  = 3'h3,
    CCU_EXTOVF = 3'h4,
    CCU_EXTPIN = 3'h5
  } ccu_clk_t;

endpackage

//--- ccu_tmr_if.sv
`timescale 1ns/1ps
interface ccu_tmr_if;
  logic        run;
  logic [2:0]  clksel;
  logic        wr;
  logic [15:0] wval;
  logic [15:0] reload;
  logic [15:0] cnt;
  logic        upd;
  logic        ovf;
  modport tmr (input run, clksel, wr, wval, reload, output cnt, upd, ovf);
  modport ctl (output run, clksel, wr, wval, reload, input cnt, upd, ovf);
endinterface

//--- ccu_timer.sv
`timescale 1ns/1ps
`include "ccu_params.svh"
module ccu_timer #(
  parameter int PW = 6           // Prescaler width
) (
  input  wire logic aclk,        // System clock
  input  wire logic aresetn,     // Synchronous reset, active low
  input  wire logic base_tick,   // Base count enable
  input  wire logic ext_ovf,     // Overflow pulse of the external timer
  input  wire logic ext_edge,    // Filtered rising edge of the count pin
  ccu_tmr_if.tmr    t            // Control and count
);
  import ccu_pkg::*;

  logic [PW-1:0] pre_q;
  logic [15:0]   cnt_q;
  logic          upd_q;
  logic          ovf_q;

  wire [PW-1:0] pmask   = PW'((7'h1 << {t.clksel[1:0], 1'b0}) - 7'h1);
  wire          pre_hit = base_tick & ((pre_q & pmask) == pmask);
  wire          src_ovf = (t.clksel == CCU_EXTOVF);
  wire          src_pin = (t.clksel == CCU_EXTPIN);
  wire          tick    = t.run & (src_ovf ? ext_ovf : src_pin ? ext_edge : (~t.clksel[2] & pre_hit)); // RULE3 RULE4
  wire          wrap    = tick & (cnt_q == 16'hffff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= '0;
      cnt_q <= `CCU_RST_CNT;
      upd_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (t.run & base_tick)
        pre_q <= pre_q + PW'(1);
      // Software write wins so a preload is never lost to a tick
      if (t.wr)
        cnt_q <= t.wval;
      else if (wrap)
        cnt_q <= t.reload; // RULE17
      else if (tick)
        cnt_q <= cnt_q + 16'h1; // RULE2
      upd_q <= tick & ~t.wr;
      ovf_q <= wrap & ~t.wr;
    end
  end

  assign t.cnt = cnt_q;
  assign t.upd = upd_q;
  assign t.ovf = ovf_q;

  property p_reload;
    @(posedge aclk) disable iff (!aresetn) ovf_q |-> cnt_q == $past(t.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("Overflow did not load the reload value"); // RULE17

  property p_step;
    @(posedge aclk) disable iff (!aresetn) (upd_q && !ovf_q) |-> cnt_q == $past(cnt_q) + 16'h1;
  endproperty
  a_step: assert property (p_step) else $error("Timer did not count by one"); // RULE2
endmodule

//--- ccu_top.sv
`timescale 1ns/1ps
`include "ccu_params.svh"
// Function
// RULE1 - Sixteen channels, one or eight cycle resolution
// RULE2 - Two independent 16-bit timers with reloads
// RULE3 - Timer clock: prescaled clock or external overflow
// RULE4 - External count inputs clock the timers
// RULE5 - Each channel picks timer and capture/compare
// RULE6 - One pin per channel, input or output
// RULE7 - Capture copies timer value on pin event
// RULE8 - Each capture raises its channel interrupt
// RULE9 - Capture edge: rising, falling or both
// RULE10 - Compare channels checked on every timer count
// RULE11 - Mode 0: interrupt only, repeats allowed
// RULE12 - Mode 1: pin toggles on every match
// RULE13 - Mode 2: one interrupt per timer period
// RULE14 - Mode 3: match sets pin, overflow clears
// RULE15 - Double register: two channels toggle one pin
// RULE16 - Single event option stops after one action
// RULE17 - Overflow loads reload value, sets period
module ccu_top #(
  parameter int AW  = 12,                  // Bus address width
  parameter int NCH = 16                   // Channel count
) (
  input  wire logic           aclk,          // System clock
  input  wire logic           aresetn,       // Synchronous reset, active low
  input  wire logic [AW-1:0]  s_axi_awaddr,  // Write address
  input  wire logic           s_axi_awvalid, // Write address valid
  output logic                s_axi_awready, // Write address ready
  input  wire logic [31:0]    s_axi_wdata,   // Write data
  input  wire logic [3:0]     s_axi_wstrb,   // Write byte strobes
  input  wire logic           s_axi_wvalid,  // Write data valid
  output logic                s_axi_wready,  // Write data ready
  output logic [1:0]          s_axi_bresp,   // Write response
  output logic                s_axi_bvalid,  // Write response valid
  input  wire logic           s_axi_bready,  // Write response ready
  input  wire logic [AW-1:0]  s_axi_araddr,  // Read address
  input  wire logic           s_axi_arvalid, // Read address valid
  output logic                s_axi_arready, // Read address ready
  output logic [31:0]         s_axi_rdata,   // Read data
  output logic [1:0]          s_axi_rresp,   // Read response
  output logic                s_axi_rvalid,  // Read data valid
  input  wire logic           s_axi_rready,  // Read data ready
  output logic                irq,           // Interrupt, active high level
  input  wire logic           ext_ovf_pulse, // Overflow pulse of the external timer
  input  wire logic [1:0]     cnt_pin,       // External count pins per timer
  input  wire logic [NCH-1:0] cc_pin_sense,  // Channel pin levels
  output logic [NCH-1:0]      cc_pin_drive,  // Channel pin output levels
  output logic [NCH-1:0]      cc_pin_en      // Channel pin output enables
);
  import ccu_pkg::*;

  localparam int SW = NCH + 2;
  localparam int HF = NCH / 2;

  logic [SW-1:0]  s1_q;
  logic [SW-1:0]  s2_q;
  logic [SW-1:0]  s3_q;
  logic [SW-1:0]  lvl_q;
  logic [2:0]     stg_q;
  logic [16:0]    tctrl_q;
  logic [15:0]    rel_q [2];
  logic [NCH-1:0] stat_q;
  logic [NCH-1:0] mask_q;
  logic [HF-1:0]  dreg_q;
  logic [15:0]    val_q [NCH];
  logic [6:0]     mode_q [NCH];
  logic [NCH-1:0] done_q;
  logic           aw_full_q;
  logic           w_full_q;
  logic [AW-1:0]  awaddr_q;
  logic [31:0]    wdata_q;
  logic [3:0]     wstrb_q;

  wire [15:0]     t_cnt [2];
  wire [1:0]      t_upd;
  wire [1:0]      t_ovf;
  wire [15:0]     val_d [NCH];
  wire [6:0]      mode_d [NCH];
  wire [NCH-1:0]  act;
  wire [NCH-1:0]  irq_ev;
  wire [NCH-1:0]  done_d;
  wire [NCH-1:0]  pin_d;
  wire [NCH-1:0]  oe_d;

  // Pin filter: a level counts once the second and third stages agree
  wire [SW-1:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
  wire [SW-1:0] rise  = lvl_d & ~lvl_q;
  wire [SW-1:0] fall  = ~lvl_d & lvl_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= {cnt_pin, cc_pin_sense};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // Staggered operation slows the timer base to one step in eight cycles
  wire stag      = tctrl_q[`CCU_F_STAG];
  wire base_tick = ~stag | (stg_q == 3'(`CCU_STAGGER - 1)); // RULE1

  always_ff @(posedge aclk) begin
    if (!aresetn)
      stg_q <= '0;
    else
      stg_q <= stg_q + 3'h1;
  end

  // Register file read, shared by the read channel and write merging
  function automatic logic [32:0] ccu_rd(input logic [11:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    if ((a & `CCU_BANK_MASK) == `CCU_VAL_BASE)
      r[15:0] = val_q[a[5:2]];
    else if ((a & `CCU_BANK_MASK) == `CCU_MODE_BASE)
      r[6:0] = mode_q[a[5:2]];
    else begin
      unique case (a)
        `CCU_TCTRL: r[16:0] = tctrl_q;
        `CCU_T0CNT: r[15:0] = t_cnt[0];
        `CCU_T0REL: r[15:0] = rel_q[0];
        `CCU_T1CNT: r[15:0] = t_cnt[1];
        `CCU_T1REL: r[15:0] = rel_q[1];
        `CCU_ISTAT: r[15:0] = stat_q;
        `CCU_IMASK: r[15:0] = mask_q;
        `CCU_DREG:  r[7:0]  = dreg_q;
        default:    r[32]   = 1'b0;
      endcase
    end
    return r;
  endfunction

  // Bus slave: address and data are held until both are present
  wire        aw_take   = s_axi_awvalid & s_axi_awready;
  wire        w_take    = s_axi_wvalid & s_axi_wready;
  wire        do_wr     = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire        aw_full_d = (aw_full_q & ~do_wr) | aw_take;
  wire        w_full_d  = (w_full_q & ~do_wr) | w_take;
  wire        bvalid_d  = (s_axi_bvalid & ~s_axi_bready) | do_wr;
  wire        ar_take   = s_axi_arvalid & s_axi_arready;
  wire        rvalid_d  = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  wire [11:0] wa        = {awaddr_q[11:2], 2'b00};
  logic [32:0] wr_old;
  logic [32:0] rd_now;
  // Procedural so a read follows register changes, not only address changes
  always_comb wr_old = ccu_rd(wa);
  always_comb rd_now = ccu_rd({s_axi_araddr[11:2], 2'b00});
  wire        wr_hit    = do_wr & wr_old[32];
  wire [31:0] wm        = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wv        = (wr_old[31:0] & ~wm) | (wdata_q & wm);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CCU_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `CCU_OKAY;
    end else begin
      aw_full_q     <= aw_full_d;
      w_full_q      <= w_full_d;
      s_axi_awready <= ~aw_full_d & ~bvalid_d;
      s_axi_wready  <= ~w_full_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (do_wr)
        s_axi_bresp <= wr_old[32] ? `CCU_OKAY : `CCU_SLVERR;
      if (ar_take) begin
        s_axi_rdata <= rd_now[31:0];
        s_axi_rresp <= rd_now[32] ? `CCU_OKAY : `CCU_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take)
      awaddr_q <= s_axi_awaddr;
    if (w_take) begin
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  // Status bits are write-one-to-clear; a new event beats the clear
  wire [NCH-1:0] st_clr = (wr_hit && wa == `CCU_ISTAT) ? (wdata_q[15:0] & wm[15:0]) : '0;
  wire [NCH-1:0] stat_d = (stat_q & ~st_clr) | irq_ev; // RULE8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tctrl_q <= `CCU_RST_TCTRL;
      stat_q  <= '0;
      mask_q  <= '0;
      dreg_q  <= '0;
      irq     <= 1'b0;
    end else begin
      if (wr_hit && wa == `CCU_TCTRL)
        tctrl_q <= wv[16:0];
      if (wr_hit && wa == `CCU_IMASK)
        mask_q <= wv[15:0];
      if (wr_hit && wa == `CCU_DREG)
        dreg_q <= wv[7:0];
      stat_q <= stat_d;
      irq    <= |(stat_q & mask_q);
    end
  end

  // Two time bases
  ccu_tmr_if tif [2] ();

  for (genvar k = 0; k < 2; k++) begin : g_tmr
    assign tif[k].run    = tctrl_q[`CCU_F_RUN0 + k * `CCU_T_STRIDE];
    assign tif[k].clksel = tctrl_q[`CCU_F_SEL0 + k * `CCU_T_STRIDE +: 3];
    assign tif[k].wr     = wr_hit & (wa == `CCU_T0CNT + 12'(8 * k));
    assign tif[k].wval   = wv[15:0];
    assign tif[k].reload = rel_q[k];
    assign t_cnt[k]      = tif[k].cnt;
    assign t_upd[k]      = tif[k].upd;
    assign t_ovf[k]      = tif[k].ovf;

    always_ff @(posedge aclk) begin
      if (!aresetn)
        rel_q[k] <= `CCU_RST_REL;
      else if (wr_hit && wa == `CCU_T0REL + 12'(8 * k))
        rel_q[k] <= wv[15:0];
    end

    ccu_timer u_tmr (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .base_tick (base_tick),
      .ext_ovf   (ext_ovf_pulse),
      .ext_edge  (rise[NCH + k]),
      .t         (tif[k])
    );
  end

  // Channel array
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int P  = (i < HF) ? i + HF : i - HF;
    localparam bit UP = (i >= HF);
    wire [6:0]  md     = mode_q[i];
    wire [2:0]  kd     = md[2:0];
    wire        ts     = md[`CCU_F_TSEL];
    wire [15:0] tv     = t_cnt[ts];
    wire        tu     = t_upd[ts];
    wire        to     = t_ovf[ts];
    wire        dr     = dreg_q[i % HF];
    wire        p_m1   = (mode_q[P][2:0] == CCU_CMP1);
    wire        m1     = (kd == CCU_CMP1);
    wire        m3     = (kd == CCU_CMP3);
    wire        once   = md[1] & md[2];
    wire        wr_val = wr_hit & (wa == `CCU_VAL_BASE + 12'(4 * i));
    wire        wr_md  = wr_hit & (wa == `CCU_MODE_BASE + 12'(4 * i));
    wire        cap    = (kd == CCU_CAP) & ((md[`CCU_F_RISE] & rise[i]) | (md[`CCU_F_FALL] & fall[i])); // RULE6 RULE9
    wire        match  = md[2] & tu & (tv == val_q[i]); // RULE5 RULE10
    // Modes 2 and 3 fire once until the next overflow of their timer
    assign act[i]    = match & ~(once & done_q[i] & ~to); // RULE13 RULE14
    assign irq_ev[i] = cap | (act[i] & md[2] & ~md[0]); // RULE8 RULE11 RULE13
    assign done_d[i] = (done_q[i] & ~to) | act[i];
    // Upper channel of a pair hands its pin to the lower one
    wire tog = (act[i] & m1 & ~(UP & dr)) | (~UP & dr & act[P] & p_m1); // RULE12 RULE15
    assign pin_d[i]  = (m3 & act[i]) ? 1'b1 : (m3 & to) ? 1'b0 : tog ? ~cc_pin_drive[i] : cc_pin_drive[i]; // RULE14
    assign oe_d[i]   = ((m1 | m3) & ~(UP & dr)) | (~UP & dr & p_m1); // RULE6
    assign val_d[i]  = cap ? tv : wr_val ? wv[15:0] : val_q[i]; // RULE7
    assign mode_d[i] = wr_md ? wv[6:0] : (md[`CCU_F_SING] & act[i]) ? {md[6:3], CCU_OFF} : md; // RULE16

    sequence s_fire2;
      act[i] && kd == CCU_CMP2;
    endsequence
    sequence s_match0;
      match && kd == CCU_CMP0;
    endsequence

    property p_cap;
      @(posedge aclk) disable iff (!aresetn) cap |=> val_q[i] == $past(tv);
    endproperty
    a_cap: assert property (p_cap) else $error("Capture did not latch the timer"); // RULE7

    property p_capirq;
      @(posedge aclk) disable iff (!aresetn) cap |=> stat_q[i];
    endproperty
    a_capirq: assert property (p_capirq) else $error("Capture did not flag its interrupt"); // RULE8

    property p_mode0;
      @(posedge aclk) disable iff (!aresetn) s_match0 |=> stat_q[i] && $stable(cc_pin_drive[i]);
    endproperty
    a_mode0: assert property (p_mode0) else $error("Interrupt-only match misbehaved"); // RULE11

    property p_toggle;
      @(posedge aclk) disable iff (!aresetn) tog |=> cc_pin_drive[i] != $past(cc_pin_drive[i]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("Pin did not toggle on match"); // RULE12

    property p_once;
      @(posedge aclk) disable iff (!aresetn) s_fire2 ##1 !to |-> !(act[i] && once);
    endproperty
    a_once: assert property (p_once) else $error("Second match fired in one period"); // RULE13

    property p_set3;
      @(posedge aclk) disable iff (!aresetn) (m3 && act[i]) |=> cc_pin_drive[i] && cc_pin_en[i];
    endproperty
    a_set3: assert property (p_set3) else $error("Set-on-match did not raise the pin"); // RULE14

    property p_clr3;
      @(posedge aclk) disable iff (!aresetn) (m3 && to && !act[i]) |=> !cc_pin_drive[i];
    endproperty
    a_clr3: assert property (p_clr3) else $error("Overflow did not clear the pin"); // RULE14

    property p_single;
      @(posedge aclk) disable iff (!aresetn) (act[i] && md[`CCU_F_SING] && !wr_md) |=> mode_q[i][2:0] == CCU_OFF;
    endproperty
    a_single: assert property (p_single) else $error("Single event did not stop the channel"); // RULE16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int j = 0; j < NCH; j++) begin
        val_q[j]  <= '0;
        mode_q[j] <= `CCU_RST_MODE;
      end
      done_q       <= '0;
      cc_pin_drive <= '0;
      cc_pin_en    <= '0;
    end else begin
      for (int j = 0; j < NCH; j++) begin
        val_q[j]  <= val_d[j];
        mode_q[j] <= mode_d[j];
      end
      done_q       <= done_d;
      cc_pin_drive <= pin_d;
      cc_pin_en    <= oe_d;
    end
  end

  property p_stagger;
    @(posedge aclk) disable iff (!aresetn) (stag && base_tick) |=> (!stag || !base_tick) [*7];
  endproperty
  a_stagger: assert property (p_stagger) else $error("Staggered base stepped too often"); // RULE1
endmodule

//--- ccu_pins.sv
`timescale 1ns/1ps
module ccu_pins (
  input  wire logic [15:0] drive, // Levels the block puts on its pins
  input  wire logic [15:0] en,    // Block output enables
  input  wire logic [15:0] ext,   // Levels from the outside sources
  output logic      [15:0] sense  // Resolved pin levels back to the block
);
  // A pin the block drives reads back its own level, so a compare pin never feeds a stale capture
  assign sense = (en & drive) | (~en & ext);
endmodule

//--- ccu_top_tb.sv
`timescale 1ns/1ps
`include "ccu_params.svh"
module ccu_top_tb;
  import ccu_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        irq;
  logic        ext_ovf_pulse;
  logic [1:0]  cnt_pin;
  logic [15:0] pin_ext;
  logic [15:0] cc_pin_sense;
  logic [15:0] cc_pin_drive;
  logic [15:0] cc_pin_en;
  int          mismatches;
  int          n_checks;
  int          gap;

  always #5 aclk = ~aclk;

  ccu_top u_ccu_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq(irq), .ext_ovf_pulse(ext_ovf_pulse), .cnt_pin(cnt_pin), .cc_pin_sense(cc_pin_sense),
    .cc_pin_drive(cc_pin_drive), .cc_pin_en(cc_pin_en));

  ccu_pins u_ccu_pins (.drive(cc_pin_drive), .en(cc_pin_en), .ext(pin_ext), .sense(cc_pin_sense));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic timeout(input string nm);
    mismatches++;
    $display("unexpected hang in %s: expected answer seen none", nm);
    give_verdict();
  endtask

  // Both channels offered at once; each released at its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = `CCU_OKAY);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 64 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1;
        s_axi_bready <= 1'b0;
        chk($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
    if (!done) timeout("write");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = `CCU_OKAY);
    bit done;
    done = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 64 && !done; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1;
        s_axi_rready <= 1'b0;
        chk($sformatf("rdata %h", a), s_axi_rdata, exp);
        chk($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
    if (!done) timeout("read");
  endtask

  // One count of timer 0; pins follow two edges after the tick
  task automatic step(input int n);
    repeat (n) begin
      @(posedge aclk);
      ext_ovf_pulse <= 1'b1;
      @(posedge aclk);
      ext_ovf_pulse <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask

  // Pins of channels 2..7, enables incl. the silent pair pin 15, then status, irq and clear
  task automatic phase(input logic [15:0] drv, input logic [15:0] st);
    chk("pin drive", {16'h0, cc_pin_drive & 16'h00fc}, {16'h0, drv});
    chk("pin enable", {16'h0, cc_pin_en & 16'h80bc}, 32'h000000a4);
    rd(`CCU_ISTAT, {16'h0, st});
    chk("irq", {31'h0, irq}, {31'h0, st[4]});
    wr(`CCU_ISTAT, {16'h0, st});
    repeat (2) @(posedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  initial begin
    aclk          = 1'b0;
    aresetn       = 1'b0;
    s_axi_awaddr  = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wstrb   = 4'hf;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    ext_ovf_pulse = 1'b0;
    cnt_pin       = 2'h0;
    pin_ext       = 16'h0000;
    mismatches    = 0;
    n_checks      = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CCU_TCTRL, 32'h0);
    rd(`CCU_T0CNT, 32'h0);
    rd(`CCU_IMASK, 32'h0);
    rd(`CCU_MODE_BASE, 32'h0);
    rd(12'h020, 32'h0, `CCU_SLVERR);
    wr(12'h020, 32'h0000ffff, `CCU_SLVERR);
    $display("test reset and map done");

    wr(`CCU_TCTRL, 32'h00000d00);
    wr(`CCU_T1CNT, 32'h00000abc);
    wr(`CCU_IMASK, 32'h00000002);
    for (int cfg = 1; cfg < 4; cfg++) begin
      wr(`CCU_MODE_BASE + 12'h004, 32'h21 | (cfg << 3));
      pin_ext[1] <= 1'b1;
      settle();
      rd(`CCU_ISTAT, {30'h0, cfg[0], 1'b0});
      chk("irq capture", {31'h0, irq}, {31'h0, cfg[0]});
      wr(`CCU_ISTAT, 32'h2);
      pin_ext[1] <= 1'b0;
      settle();
      rd(`CCU_ISTAT, {30'h0, cfg[1], 1'b0});
      wr(`CCU_ISTAT, 32'h2);
    end
    rd(`CCU_VAL_BASE + 12'h004, 32'h00000abc);
    wr(`CCU_TCTRL, 32'h00000b00);
    repeat (3) begin
      cnt_pin[1] <= 1'b1;
      repeat (4) @(posedge aclk);
      cnt_pin[1] <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    pin_ext[1] <= 1'b1;
    settle();
    rd(`CCU_VAL_BASE + 12'h004, 32'h00000abf);
    wr(`CCU_MODE_BASE + 12'h004, 32'h0);
    rd(`CCU_ISTAT, 32'h00000002);
    wr(`CCU_ISTAT, 32'h00000002);
    $display("test capture done");

    wr(`CCU_T0REL, 32'h000000fe);
    wr(`CCU_TCTRL, 32'h00000009);
    wr(`CCU_IMASK, 32'h00000010);
    for (int i = 2; i < 8; i++) wr(`CCU_VAL_BASE + 12'(4 * i), 32'h00000100);
    wr(`CCU_VAL_BASE + 12'h03c, 32'h000000fe);
    wr(`CCU_MODE_BASE + 12'h008, 32'h5);
    wr(`CCU_MODE_BASE + 12'h00c, 32'h4);
    wr(`CCU_MODE_BASE + 12'h010, 32'h6);
    wr(`CCU_MODE_BASE + 12'h014, 32'h7);
    wr(`CCU_MODE_BASE + 12'h018, 32'h45);
    wr(`CCU_MODE_BASE + 12'h01c, 32'h5);
    wr(`CCU_MODE_BASE + 12'h03c, 32'h5);
    wr(`CCU_DREG, 32'h00000080);
    wr(`CCU_T0CNT, 32'h000000ff);
    step(1);
    phase(16'h00e4, 16'h0018);
    wr(`CCU_T0CNT, 32'h000000ff);
    step(1);
    phase(16'h0060, 16'h0008);
    rd(`CCU_MODE_BASE + 12'h018, 32'h00000040);
    wr(`CCU_T0CNT, 32'h0000ffff);
    step(1);
    rd(`CCU_T0CNT, 32'h000000fe);
    phase(16'h00c0, 16'h0000);
    step(2);
    phase(16'h0064, 16'h0018);
    $display("test compare done");

    // Neighbouring matches land one timer step apart: eight cycles staggered, four at divide by four
    wr(`CCU_MODE_BASE + 12'h020, 32'h5);
    wr(`CCU_MODE_BASE + 12'h024, 32'h5);
    wr(`CCU_VAL_BASE + 12'h020, 32'h00000040);
    wr(`CCU_VAL_BASE + 12'h024, 32'h00000041);
    for (int sc = 0; sc < 2; sc++) begin
      wr(`CCU_TCTRL, 32'h0);
      wr(`CCU_T0CNT, 32'h0);
      wr(`CCU_TCTRL, sc ? 32'h00000003 : 32'h00010001);
      gap = 0;
      for (int i = 0; i < 2000 && cc_pin_drive[8] == sc[0]; i++) @(posedge aclk);
      for (int i = 0; i < 64 && cc_pin_drive[9] == sc[0]; i++) begin
        @(posedge aclk);
        gap++;
      end
      chk("count gap", gap, sc ? 4 : 8);
    end
    $display("test timing done");
    give_verdict();
  end
endmodule
